// ### core/dpwm_map.svh
// Register indices, field positions, reset values and prescaler counts
// for the dual PWM block.
// Assumes an APB slave where byte address = 4 x register index.
`ifndef DPWM_MAP_SVH
`define DPWM_MAP_SVH

// Register indices; the byte address is four times the index.
`define DPWM_IDX_PWMCTL 8'h07
`define DPWM_IDX_TMRCTL 8'h08
`define DPWM_IDX_PERIOD_A 8'h09
`define DPWM_IDX_PERIOD_B 8'h0a
`define DPWM_IDX_DUTY_A 8'h0b
`define DPWM_IDX_DUTY_B 8'h0c
`define DPWM_IDX_STATUS 8'h0d
`define DPWM_IDX_MASK 8'h0e
`define DPWM_IDX_COUNTERS 8'h0f
`define DPWM_IDX_LATCHES 8'h10
`define DPWM_IDX_SLEEP 8'h11

// Field positions of the timer control register.
`define DPWM_TMR_EN_B 7
`define DPWM_TMR_EN_A 6
`define DPWM_TMR_PS_B_HI 5
`define DPWM_TMR_PS_B_LO 3
`define DPWM_TMR_PS_A_HI 2
`define DPWM_TMR_PS_A_LO 0

// Field positions of the PWM control, status and mask registers.
`define DPWM_BIT_A 0
`define DPWM_BIT_B 1

// Reset values.
`define DPWM_RST_BYTE 8'h00
`define DPWM_RST_FLAGS 2'h0
`define DPWM_RST_WORD 32'h0000_0000

// Last prescaler count per select code (ratio minus one).
`define DPWM_PS_LAST0 8'h00
`define DPWM_PS_LAST1 8'h01
`define DPWM_PS_LAST2 8'h03
`define DPWM_PS_LAST3 8'h07
`define DPWM_PS_LAST4 8'h0f
`define DPWM_PS_LAST5 8'h3f
`define DPWM_PS_LAST6 8'h7f
`define DPWM_PS_LAST7 8'hff

`endif

// ### core/dpwm_pkg.sv
// Types shared by the dual PWM block and its channel module.
// Assumes the constants of dpwm_map.svh for field meanings.
package dpwm_pkg;

    // Settings that steer one channel.
    typedef struct packed {
        logic [7:0] period;
        logic [7:0] duty;
        logic [2:0] prescale_sel;
        logic counter_enable;
        logic output_enable;
        logic run_allowed;
    } dpwm_chan_cfg_s;

    // State of one channel.
    typedef struct packed {
        logic [7:0] presc;
        logic [7:0] channel_counter;
        logic [7:0] duty_latch;
        logic pulse_out;
    } dpwm_chan_state_s;

    // State of the register file and bus slave.
    typedef struct packed {
        logic [1:0] pwm_enable;
        logic [7:0] tmrctl;
        logic [7:0] period_a;
        logic [7:0] period_b;
        logic [7:0] duty_buffer_a;
        logic [7:0] duty_buffer_b;
        logic [1:0] status;
        logic [1:0] mask;
        logic sleep_instruction;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } dpwm_top_state_s;

endpackage

// ### core/dpwm_chan.sv
// One PWM channel: prescaler, 8-bit counter, duty latch and output.
// Assumes configuration comes from registers in the same clock domain.
`timescale 1ns/1ps
`default_nettype none
`include "dpwm_map.svh"

module dpwm_chan
    import dpwm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Configuration.
    input wire dpwm_chan_cfg_s cfg,
    // Channel state.
    output logic [7:0] channel_counter,
    output logic [7:0] duty_latch,
    output logic pulse_out,
    output logic channel_period_flag
);

    dpwm_chan_state_s s_reg;
    dpwm_chan_state_s s_next;
    logic [7:0] ps_last;
    logic run;
    logic tick;
    logic at_period;

    // Terminal prescaler count for the selected ratio.
    always_comb begin
        case (cfg.prescale_sel)
            3'h0: ps_last = `DPWM_PS_LAST0;
            3'h1: ps_last = `DPWM_PS_LAST1;
            3'h2: ps_last = `DPWM_PS_LAST2;
            3'h3: ps_last = `DPWM_PS_LAST3;
            3'h4: ps_last = `DPWM_PS_LAST4;
            3'h5: ps_last = `DPWM_PS_LAST5;
            3'h6: ps_last = `DPWM_PS_LAST6;
            default: ps_last = `DPWM_PS_LAST7;
        endcase
    end

    // Counting is allowed only when enabled and not held by sleep.
    assign run = cfg.counter_enable & cfg.run_allowed;
    // Greater-or-equal lets a ratio cut mid-count tick at once instead
    // of wrapping the prescaler through all of its states first.
    assign tick = run & (s_reg.presc >= ps_last);
    assign at_period = s_reg.channel_counter == cfg.period;

    // Next state: prescaler, counter, duty latch and output level.
    always_comb begin
        s_next = s_reg;
        channel_period_flag = 1'b0;
        // A stopped timer restarts its prescaler from zero.
        if (!run || tick) begin
            s_next.presc = 8'h00;
        end else begin
            s_next.presc = s_reg.presc + 8'h01;
        end
        if (tick) begin
            if (at_period) begin
                s_next.channel_counter = 8'h00;
                s_next.duty_latch = cfg.duty;
                s_next.pulse_out = (cfg.duty != 8'h00);
                channel_period_flag = 1'b1;
            end else begin
                s_next.channel_counter = s_reg.channel_counter + 8'h01;
                // The pin falls as the counter reaches the duty latch, so
                // the high phase lasts exactly duty ticks.
                if (s_next.channel_counter == s_reg.duty_latch) begin
                    s_next.pulse_out = 1'b0;
                end
            end
        end
        if (!cfg.output_enable) begin
            s_next.pulse_out = 1'b0;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign channel_counter = s_reg.channel_counter;
    assign duty_latch = s_reg.duty_latch;
    assign pulse_out = s_reg.pulse_out;

endmodule
`default_nettype wire

// ### core/dpwm_top.sv
// Dual 8-bit PWM generator with period timers and an APB register file.
// Assumes a single 40 MHz pclk, an APB master in the same domain and
// a conversion_running level from the converter in the same domain.
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dpwm_map.svh"

// Functional notes
// - Two PWM outputs, each 8-bit resolution from period and duty.
// - Each channel has an 8-bit up-counter behind a prescaler.
// - Timer control bit 6 enables counter A, bit 7 counter B.
// - Counter equal to period: clear, output high, latch duty, flag.
// - A zero duty keeps the output low for the whole period.
// - Period lasts (period + 1) times the prescaler ratio in clocks.
// - Duty latch equal to counter drives the output low.
// - Duty buffer writable anytime; latched only at a period boundary.
// - High time equals duty times the prescaler ratio in clocks.
// - The flag sets in the cycle the period match raises the output.
// - Three-bit prescaler select gives 1,2,4,8,16,64,128,256; zero is 1.
// - Both prescaler selects clear on every reset.
// - In sleep both counters stop unless a conversion is running.
// - During sleep the PWM logic keeps its clock.
module dpwm_top
    import dpwm_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Converter status, used for the sleep hold.
    input wire logic conversion_running,
    // Interrupt.
    output logic irq,
    // PWM pins.
    output logic pulse_out_a,
    output logic pulse_out_b
);

    dpwm_top_state_s s_reg;
    dpwm_top_state_s s_next;

    // Channel configuration and results.
    dpwm_chan_cfg_s cfg_a;
    dpwm_chan_cfg_s cfg_b;
    logic [7:0] counter_a;
    logic [7:0] counter_b;
    logic [7:0] duty_latch_a;
    logic [7:0] duty_latch_b;
    logic flag_a;
    logic flag_b;
    logic [1:0] period_events;

    // Bus decode helpers.
    logic setup_phase;
    logic access_done;
    logic [7:0] reg_index;
    logic addr_ok;
    logic hit_pwmctl;
    logic hit_tmrctl;
    logic hit_period_a;
    logic hit_period_b;
    logic hit_duty_a;
    logic hit_duty_b;
    logic hit_status;
    logic hit_mask;
    logic hit_counters;
    logic hit_latches;
    logic hit_sleep;
    logic mapped;
    logic lane0;
    logic run_allowed;
    logic [31:0] read_word;

    // The counters stop in sleep only if the converter is idle; the
    // clock itself is never gated here so PWM keeps running.
    assign run_allowed = ~s_reg.sleep_instruction
        | conversion_running;

    // Channel A settings.
    always_comb begin
        cfg_a.period = s_reg.period_a;
        cfg_a.duty = s_reg.duty_buffer_a;
        cfg_a.prescale_sel =
            s_reg.tmrctl[`DPWM_TMR_PS_A_HI:`DPWM_TMR_PS_A_LO];
        cfg_a.counter_enable = s_reg.tmrctl[`DPWM_TMR_EN_A];
        cfg_a.output_enable = s_reg.pwm_enable[`DPWM_BIT_A];
        cfg_a.run_allowed = run_allowed;
    end

    // Channel B settings.
    always_comb begin
        cfg_b.period = s_reg.period_b;
        cfg_b.duty = s_reg.duty_buffer_b;
        cfg_b.prescale_sel =
            s_reg.tmrctl[`DPWM_TMR_PS_B_HI:`DPWM_TMR_PS_B_LO];
        cfg_b.counter_enable = s_reg.tmrctl[`DPWM_TMR_EN_B];
        cfg_b.output_enable = s_reg.pwm_enable[`DPWM_BIT_B];
        cfg_b.run_allowed = run_allowed;
    end

    // Channel A.
    dpwm_chan u_chan_a (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_a),
        .channel_counter(counter_a),
        .duty_latch(duty_latch_a),
        .pulse_out(pulse_out_a),
        .channel_period_flag(flag_a)
    );

    // Channel B.
    dpwm_chan u_chan_b (
        .pclk(pclk),
        .presetn(presetn),
        .cfg(cfg_b),
        .channel_counter(counter_b),
        .duty_latch(duty_latch_b),
        .pulse_out(pulse_out_b),
        .channel_period_flag(flag_b)
    );

    assign period_events = {flag_b, flag_a};

    // APB phases. The slave answers with pready in the first access
    // cycle, so every transfer is two cycles with no wait states.
    assign setup_phase = psel & ~penable;
    assign access_done = psel & penable & s_reg.pready;
    assign reg_index = paddr[9:2];
    assign addr_ok = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0);
    // Registers are eight bits wide, so only byte lane 0 stores.
    assign lane0 = pstrb[0];

    // Address decode.
    always_comb begin
        hit_pwmctl = 1'b0;
        hit_tmrctl = 1'b0;
        hit_period_a = 1'b0;
        hit_period_b = 1'b0;
        hit_duty_a = 1'b0;
        hit_duty_b = 1'b0;
        hit_status = 1'b0;
        hit_mask = 1'b0;
        hit_counters = 1'b0;
        hit_latches = 1'b0;
        hit_sleep = 1'b0;
        if (!addr_ok) begin
            hit_pwmctl = 1'b0;
        end else if (reg_index == `DPWM_IDX_PWMCTL) begin
            hit_pwmctl = 1'b1;
        end else if (reg_index == `DPWM_IDX_TMRCTL) begin
            hit_tmrctl = 1'b1;
        end else if (reg_index == `DPWM_IDX_PERIOD_A) begin
            hit_period_a = 1'b1;
        end else if (reg_index == `DPWM_IDX_PERIOD_B) begin
            hit_period_b = 1'b1;
        end else if (reg_index == `DPWM_IDX_DUTY_A) begin
            hit_duty_a = 1'b1;
        end else if (reg_index == `DPWM_IDX_DUTY_B) begin
            hit_duty_b = 1'b1;
        end else if (reg_index == `DPWM_IDX_STATUS) begin
            hit_status = 1'b1;
        end else if (reg_index == `DPWM_IDX_MASK) begin
            hit_mask = 1'b1;
        end else if (reg_index == `DPWM_IDX_COUNTERS) begin
            hit_counters = 1'b1;
        end else if (reg_index == `DPWM_IDX_LATCHES) begin
            hit_latches = 1'b1;
        end else if (reg_index == `DPWM_IDX_SLEEP) begin
            hit_sleep = 1'b1;
        end
    end

    assign mapped = hit_pwmctl | hit_tmrctl | hit_period_a | hit_period_b
        | hit_duty_a | hit_duty_b | hit_status | hit_mask | hit_counters
        | hit_latches | hit_sleep;

    // Read multiplexer; unused bits read as zero.
    always_comb begin
        read_word = `DPWM_RST_WORD;
        if (hit_pwmctl) begin
            read_word[1:0] = s_reg.pwm_enable;
        end else if (hit_tmrctl) begin
            read_word[7:0] = s_reg.tmrctl;
        end else if (hit_period_a) begin
            read_word[7:0] = s_reg.period_a;
        end else if (hit_period_b) begin
            read_word[7:0] = s_reg.period_b;
        end else if (hit_duty_a) begin
            read_word[7:0] = s_reg.duty_buffer_a;
        end else if (hit_duty_b) begin
            read_word[7:0] = s_reg.duty_buffer_b;
        end else if (hit_status) begin
            read_word[1:0] = s_reg.status;
        end else if (hit_mask) begin
            read_word[1:0] = s_reg.mask;
        end else if (hit_counters) begin
            // Counters are visible to software only, never writable.
            read_word[15:0] = {counter_b, counter_a};
        end else if (hit_latches) begin
            read_word[15:0] = {duty_latch_b, duty_latch_a};
        end else if (hit_sleep) begin
            read_word[0] = s_reg.sleep_instruction;
        end
    end

    // Next state of the register file and bus outputs.
    always_comb begin
        s_next = s_reg;
        // One-cycle ready: raised after setup, dropped after access.
        s_next.pready = setup_phase;
        s_next.pslverr = setup_phase & ~mapped;
        if (setup_phase) begin
            s_next.prdata = pwrite ? `DPWM_RST_WORD : read_word;
        end
        // Writes land only at the completing access edge. Duty buffers
        // may change at any time; the channel latches them later.
        if (access_done && pwrite && lane0) begin
            if (hit_pwmctl) begin
                s_next.pwm_enable = pwdata[1:0];
            end else if (hit_tmrctl) begin
                s_next.tmrctl = pwdata[7:0];
            end else if (hit_period_a) begin
                s_next.period_a = pwdata[7:0];
            end else if (hit_period_b) begin
                s_next.period_b = pwdata[7:0];
            end else if (hit_duty_a) begin
                s_next.duty_buffer_a = pwdata[7:0];
            end else if (hit_duty_b) begin
                s_next.duty_buffer_b = pwdata[7:0];
            end else if (hit_status) begin
                s_next.status = s_reg.status & ~pwdata[1:0];
            end else if (hit_mask) begin
                s_next.mask = pwdata[1:0];
            end else if (hit_sleep) begin
                s_next.sleep_instruction = pwdata[0];
            end
        end
        // A period event in the clearing cycle is kept: set wins.
        s_next.status = s_next.status | period_events;
        s_next.irq = |(s_next.status & s_next.mask);
    end

    // State register. Reset clears every field, including both
    // prescaler selects in the timer control register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Bus and interrupt outputs come straight from the state register.
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign irq = s_reg.irq;

endmodule
`default_nettype wire

// ### sim/dpwm_load.sv
// Passive load on one PWM pin: measures high time and period in clocks.
// Assumes the pin is a registered level in the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module dpwm_load (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Pin under observation.
    input wire logic pin,
    // Last widths seen and count of rising edges.
    output int high_len,
    output int per_len,
    output int rises
);
    int cnt;
    logic last;

    // A load has no timing of its own, so it only counts what it sees.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            last <= 1'b0;
            high_len <= 0;
            per_len <= 0;
            rises <= 0;
        end else begin
            last <= pin;
            cnt <= cnt + 1;
            if (pin && !last) begin
                per_len <= cnt;
                cnt <= 1;
                rises <= rises + 1;
            end
            if (!pin && last) begin
                high_len <= cnt;
            end
        end
    end
endmodule
`default_nettype wire

// ### sim/dpwm_top_sva.sv
// Bus and interrupt checks for the dual PWM block.
// Assumes it is bound to dpwm_top and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "dpwm_map.svh"

module dpwm_top_sva (
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt.
    input wire logic irq
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic mapped;
    logic flag_wr;

    // Decode of the register window and of writes that can lower irq.
    assign mapped = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0
        && paddr[9:2] >= `DPWM_IDX_PWMCTL && paddr[9:2] <= `DPWM_IDX_SLEEP;
    assign flag_wr = psel && penable && pready && pwrite && pstrb[0]
        && (paddr[9:2] == `DPWM_IDX_STATUS || paddr[9:2] == `DPWM_IDX_MASK);

    sequence apb_setup;
        psel && !penable;
    endsequence
    sequence apb_answer;
        psel && penable && pready;
    endsequence

    answer_time_a: assert property (apb_setup |=> apb_answer)
        else $error("no answer one cycle after setup");
    ready_single_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    ready_origin_a: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    wr_data_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
        else $error("read data on a write");
    bad_addr_a: assert property (pready && !mapped |-> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    good_addr_a: assert property (pready && mapped |-> !pslverr)
        else $error("mapped access refused");
    irq_fall_a: assert property ($fell(irq) |-> $past(flag_wr))
        else $error("irq fell without status or mask write");
endmodule

bind dpwm_top dpwm_top_sva u_sva (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq));
`default_nettype wire

// ### sim/dpwm_top_tb.sv
// Self-checking bench for the dual PWM block over APB.
// Assumes dpwm_top, dpwm_load and the bound checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "dpwm_map.svh"

module dpwm_top_tb
    import dpwm_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic conversion_running = 0, rerr, pready, pslverr, irq;
    logic pulse_out_a, pulse_out_b;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    int err_total = 0, total_checks = 0;
    int ha, pa, ra, hb, pb, rb;
    int rt[8] = '{1, 2, 4, 8, 16, 64, 128, 256};

    dpwm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .conversion_running(conversion_running), .irq(irq),
        .pulse_out_a(pulse_out_a), .pulse_out_b(pulse_out_b));
    dpwm_load load_a (.pclk(pclk), .presetn(presetn), .pin(pulse_out_a),
        .high_len(ha), .per_len(pa), .rises(ra));
    dpwm_load load_b (.pclk(pclk), .presetn(presetn), .pin(pulse_out_b),
        .high_len(hb), .per_len(pb), .rises(rb));

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high.
    task automatic apb(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Sample pready at rising edges only; data is taken at that edge.
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_total++;
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Bounded wait for rising-edge totals on both pins.
    task automatic wrise(input int na, input int nb);
        int k;
        k = 0;
        while ((ra < na || rb < nb) && k < 9000) begin
            @(posedge pclk);
            k++;
        end
        if (k >= 9000) begin
            err_total++;
        end
    endtask

    task automatic t_reset;
        for (int i = 7; i <= 17; i++) begin
            apb(1'b0, 8'(i), 0);
            chk("reset value", rdat, 32'h0);
        end
        apb(1'b0, 8'h12, 0);
        chk("unmapped error", 32'(rerr), 32'h1);
    endtask

    // Every prescaler code on both channels; setup in the documented order.
    task automatic t_wave;
        apb(1'b1, `DPWM_IDX_PERIOD_A, 32'h3);
        apb(1'b1, `DPWM_IDX_PERIOD_B, 32'h5);
        apb(1'b1, `DPWM_IDX_DUTY_A, 32'h2);
        apb(1'b1, `DPWM_IDX_DUTY_B, 32'h1);
        apb(1'b1, `DPWM_IDX_MASK, 32'h3);
        apb(1'b1, `DPWM_IDX_PWMCTL, 32'h3);
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `DPWM_IDX_TMRCTL, {24'h0, 2'b11, 3'(7 - i), 3'(i)});
            wrise(ra + 3, rb + 3);
            chk("period a", pa, 4 * rt[i]);
            chk("high a", ha, 2 * rt[i]);
            chk("period b", pb, 6 * rt[7 - i]);
            chk("high b", hb, rt[7 - i]);
        end
    endtask

    // A duty written mid-period waits for the next boundary.
    task automatic t_duty;
        apb(1'b1, `DPWM_IDX_TMRCTL, 32'hc7);
        wrise(ra + 2, 0);
        apb(1'b1, `DPWM_IDX_DUTY_A, 32'h1);
        apb(1'b0, `DPWM_IDX_LATCHES, 0);
        chk("latch kept", rdat[7:0], 8'h02);
        wrise(ra + 1, 0);
        apb(1'b0, `DPWM_IDX_LATCHES, 0);
        chk("latch moved", rdat[7:0], 8'h01);
        wrise(ra + 1, 0);
        chk("new high", ha, 256);
    endtask

    // Zero duty: pin stays low but the period flag still rises.
    task automatic t_zero;
        int r;
        apb(1'b1, `DPWM_IDX_DUTY_A, 32'h0);
        apb(1'b1, `DPWM_IDX_TMRCTL, 32'hc0);
        repeat (20) @(posedge pclk);
        r = ra;
        apb(1'b1, `DPWM_IDX_STATUS, 32'h3);
        repeat (20) @(posedge pclk);
        chk("zero duty rises", ra, r);
        apb(1'b0, `DPWM_IDX_STATUS, 0);
        chk("flag a", rdat[0], 1'b1);
    endtask

    // Counters held when disabled; interrupt masked, unmasked, cleared.
    task automatic t_irq;
        logic [31:0] c;
        apb(1'b1, `DPWM_IDX_TMRCTL, 32'h0);
        apb(1'b0, `DPWM_IDX_COUNTERS, 0);
        c = rdat;
        apb(1'b0, `DPWM_IDX_COUNTERS, 0);
        chk("held counters", rdat, c);
        // The irq flop updates at the write edge, so look one edge later.
        apb(1'b1, `DPWM_IDX_MASK, 32'h0);
        @(posedge pclk);
        chk("masked irq", 32'(irq), 32'h0);
        apb(1'b1, `DPWM_IDX_MASK, 32'h1);
        @(posedge pclk);
        chk("unmasked irq", 32'(irq), 32'h1);
        apb(1'b1, `DPWM_IDX_STATUS, 32'h3);
        @(posedge pclk);
        chk("cleared irq", 32'(irq), 32'h0);
        apb(1'b0, `DPWM_IDX_STATUS, 0);
        chk("cleared status", rdat, 32'h0);
    endtask

    // Sleep stops the counters unless a conversion is running.
    task automatic t_sleep;
        logic [31:0] c;
        apb(1'b1, `DPWM_IDX_PERIOD_A, 32'hff);
        apb(1'b1, `DPWM_IDX_TMRCTL, 32'h40);
        apb(1'b1, `DPWM_IDX_SLEEP, 32'h1);
        apb(1'b0, `DPWM_IDX_COUNTERS, 0);
        c = rdat;
        apb(1'b0, `DPWM_IDX_COUNTERS, 0);
        chk("sleep hold", rdat, c);
        conversion_running <= 1'b1;
        apb(1'b0, `DPWM_IDX_COUNTERS, 0);
        c = rdat;
        apb(1'b0, `DPWM_IDX_COUNTERS, 0);
        chk("sleep run", 32'(rdat != c), 32'h1);
    endtask

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Clock of 25 ns.
    initial begin
        forever #12.5 pclk = ~pclk;
    end

    // Main sequence after five clocks of reset.
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_wave();
        t_duty();
        t_zero();
        t_irq();
        t_sleep();
        stop_test();
    end

    // The tests need well under this many clocks; a hang ends here.
    initial begin
        repeat (90000) @(posedge pclk);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
